// ===== logic/pcr_protection_config_regs.sv
// Protection configuration words and the fault response logic they steer.
// Assumes command words arrive already decoded from the management bus on i_clk,
// and that fault comparator levels and the enable pin are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: NV lockout log only during delivery when set
// R2: Reserved bits store value, change nothing
// R3: Stage overcurrent enabled; latch or hiccup select
// R4: Output max overvolt enabled; latch or hiccup
// R5: Die overtemp bit set means disabled
// R6: External overtemp bit set means disabled
// R7: Input fault latches or hiccups per select
// R8: Input disable bit kills lockout and overvolt
// R9: Status lockout post only during delivery when set
// R10: Clear status on restart, pin off, off
// R11: Four selected-clock ticks before arming window
// R12: Master disable spares spike protections
// R13: Overvolt mode: none, latch, hiccup, retry
// R14: Retry select picks three or six
// R15: Overvolt persists delay times 200 ns
// R16: Undervolt mode: none, latch, hiccup, six retries
// R17: Undervolt persists delay times 20 us
// R18: Persistence count restarts when fault clears
module pcr_protection_config_regs #(
	parameter int UV_LSB_CYC   = pcr_pkg::UV_LSB_CYC,
	parameter int ARM_SLOW_CYC = pcr_pkg::ARM_SLOW_CYC,
	parameter int ARM_FAST_CYC = pcr_pkg::ARM_FAST_CYC
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_resetn,
	input  wire logic [7:0]             i_cmd,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	input  wire logic [15:0]            i_wdata,
	input  wire pcr_pkg::pcr_fault_in_t i_faults,
	input  wire logic                   i_restart,
	input  wire logic                   i_op_off,
	output logic [15:0]                 o_rdata,
	output logic                        o_ack,
	output logic                        o_nack,
	output pcr_pkg::pcr_resp_t          o_resp,
	output pcr_pkg::pcr_active_t        o_active,
	output logic                        o_nv_log,
	output logic                        o_status_post,
	output logic                        o_status_clear
);
	import pcr_pkg::*;

	localparam int FW = $bits(pcr_fault_in_t);

	// Register bank
	logic [15:0] prot_cfg;
	logic [15:0] vout_win;
	wire         hit_prot = (i_cmd == CMD_PROT_CFG);
	wire         hit_win  = (i_cmd == CMD_VOUT_WIN);
	wire         hit_any  = hit_prot | hit_win;
	wire  [15:0] rd_mux   = hit_prot ? prot_cfg : (hit_win ? vout_win : 16'h0000);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prot_cfg <= PROT_CFG_RESET;
			vout_win <= VOUT_WIN_RESET;
		end else if (i_wr) begin
			// Whole word stored, reserved bits included R2
			if (hit_prot)
				prot_cfg <= i_wdata;
			if (hit_win)
				vout_win <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 16'h0000;
			o_ack   <= 1'b0;
			o_nack  <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_mux : o_rdata;
			o_ack   <= (i_rd | i_wr) & hit_any;
			o_nack  <= (i_rd | i_wr) & ~hit_any;
		end
	end

	// Field decode
	wire       master_on     = ~prot_cfg[MASTER_DIS_BIT];
	wire       vin_en        = master_on & ~prot_cfg[INPUT_PROT_DIS_BIT]; // R8
	wire       stage_oc_en   = master_on & prot_cfg[STAGE_OC_EN_BIT]; // R3
	wire       out_ov_en     = master_on & prot_cfg[OUT_MAX_OV_EN_BIT]; // R4
	wire       die_ot_en     = master_on & ~prot_cfg[DIE_OT_DIS_BIT]; // R5
	wire       ext_ot_en     = master_on & ~prot_cfg[EXT_OT_DIS_BIT]; // R6
	wire [1:0] ov_mode       = vout_win[VID_OV_MODE_LSB +: 2];
	wire [1:0] uv_mode       = vout_win[VID_UV_MODE_LSB +: 2];
	wire [4:0] ov_delay      = vout_win[VID_OV_DELAY_LSB +: 5];
	wire [5:0] uv_delay      = vout_win[VID_UV_DELAY_LSB +: 6];
	wire [2:0] ov_retry_max  = pcr_retry_limit(vout_win[VID_OV_RETRY_SEL_BIT]); // R14
	wire [2:0] uv_retry_max  = pcr_retry_limit(1'b0); // R16

	// Two-stage synchroniser; the second stage and its one-cycle delayed copy feed logic
	logic [FW-1:0] sync_a;
	logic [FW-1:0] sync_b;
	logic [FW-1:0] prev_b;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_a <= '0;
			sync_b <= '0;
			prev_b <= '0;
		end else begin
			sync_a <= i_faults;
			sync_b <= sync_a;
			prev_b <= sync_b;
		end
	end
	pcr_fault_in_t flt;
	pcr_fault_in_t flt_prev;
	assign flt      = pcr_fault_in_t'(sync_b);
	assign flt_prev = pcr_fault_in_t'(prev_b);

	wire vin_uv_rise  = flt.vin_uv & ~flt_prev.vin_uv;
	wire vin_ov_rise  = flt.vin_ov & ~flt_prev.vin_ov;
	wire oc_rise      = flt.stage_oc & ~flt_prev.stage_oc;
	wire out_ov_rise  = flt.out_max_ov & ~flt_prev.out_max_ov;
	wire die_rise     = flt.die_ot & ~flt_prev.die_ot;
	wire ext_rise     = flt.ext_ot & ~flt_prev.ext_ot;
	wire spike_rise   = flt.high_spike_shutdown & ~flt_prev.high_spike_shutdown;
	wire ton_rise     = flt.ton_normal & ~flt_prev.ton_normal;
	wire en_fall      = flt_prev.en_pin & ~flt.en_pin;
	wire power_off    = en_fall | i_op_off;

	// Arming delay after on-time settles
	pcr_arm_state_t arm_state;
	pcr_arm_state_t next_arm_state;
	logic [15:0]    arm_cyc;
	logic [2:0]     arm_ticks;
	wire  [15:0]    arm_period = prot_cfg[ARM_CLK_SEL_BIT] ? 16'(ARM_SLOW_CYC)
	                                                       : 16'(ARM_FAST_CYC);
	wire            arm_tick   = (arm_cyc >= arm_period - 16'h0001);
	wire            ton_lost   = ~flt.ton_normal | power_off;

	always_comb begin
		next_arm_state = arm_state;
		case (arm_state)
			ARM_IDLE: begin
				if (ton_rise)
					next_arm_state = ARM_WAIT;
			end
			ARM_WAIT: begin
				if (ton_lost)
					next_arm_state = ARM_IDLE;
				else if (arm_tick && arm_ticks == ARM_TICKS - 3'h1)
					next_arm_state = ARM_READY; // R11
			end
			ARM_READY: begin
				if (ton_lost)
					next_arm_state = ARM_IDLE;
			end
			default: next_arm_state = ARM_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			arm_state <= ARM_IDLE;
			arm_cyc   <= 16'h0000;
			arm_ticks <= 3'h0;
		end else begin
			arm_state <= next_arm_state;
			if (arm_state != ARM_WAIT || ton_lost) begin
				arm_cyc   <= 16'h0000;
				arm_ticks <= 3'h0;
			end else if (arm_tick) begin
				arm_cyc   <= 16'h0000;
				arm_ticks <= arm_ticks + 3'h1; // R11
			end else begin
				arm_cyc <= arm_cyc + 16'h0001;
			end
		end
	end

	wire window_armed = master_on & (arm_state == ARM_READY);
	wire ov_cond      = window_armed & flt.vid_ov & (ov_mode != MODE_NONE);
	wire uv_cond      = window_armed & flt.vid_uv & (uv_mode != MODE_NONE);

	// Persistence timers: prescaler per LSB, then LSB count against the delay
	logic [5:0]  ov_pre;
	logic [4:0]  ov_lsb;
	logic        ov_fired;
	logic [15:0] uv_pre;
	logic [5:0]  uv_lsb;
	logic        uv_fired;
	wire ov_trip = ov_cond & ~ov_fired & (ov_lsb >= ov_delay); // R15
	wire uv_trip = uv_cond & ~uv_fired & (uv_lsb >= uv_delay); // R17

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ov_pre   <= 6'h00;
			ov_lsb   <= 5'h00;
			ov_fired <= 1'b0;
		end else if (!ov_cond) begin
			ov_pre   <= 6'h00; // R18
			ov_lsb   <= 5'h00;
			ov_fired <= 1'b0;
		end else if (ov_trip) begin
			ov_fired <= 1'b1;
		end else if (!ov_fired) begin
			if (ov_pre == 6'(OV_LSB_CYC - 1)) begin
				ov_pre <= 6'h00;
				ov_lsb <= ov_lsb + 5'h01; // R15
			end else begin
				ov_pre <= ov_pre + 6'h01;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			uv_pre   <= 16'h0000;
			uv_lsb   <= 6'h00;
			uv_fired <= 1'b0;
		end else if (!uv_cond) begin
			uv_pre   <= 16'h0000; // R18
			uv_lsb   <= 6'h00;
			uv_fired <= 1'b0;
		end else if (uv_trip) begin
			uv_fired <= 1'b1;
		end else if (!uv_fired) begin
			if (uv_pre == 16'(UV_LSB_CYC - 1)) begin
				uv_pre <= 16'h0000;
				uv_lsb <= uv_lsb + 6'h01; // R17
			end else begin
				uv_pre <= uv_pre + 16'h0001;
			end
		end
	end

	// Retry budgets; refilled only at power-off so retries cannot loop forever
	logic [2:0] ov_retries;
	logic [2:0] uv_retries;
	wire ov_retry_ok = (ov_retries < ov_retry_max);
	wire uv_retry_ok = (uv_retries < uv_retry_max);
	wire ov_do_retry = ov_trip & (ov_mode == MODE_RETRY) & ov_retry_ok; // R13
	wire uv_do_retry = uv_trip & (uv_mode == MODE_RETRY) & uv_retry_ok; // R16

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ov_retries <= 3'h0;
			uv_retries <= 3'h0;
		end else begin
			if (power_off)
				ov_retries <= 3'h0;
			else if (ov_do_retry)
				ov_retries <= ov_retries + 3'h1;
			if (power_off)
				uv_retries <= 3'h0;
			else if (uv_do_retry)
				uv_retries <= uv_retries + 3'h1;
		end
	end

	// Response requests per source
	wire oc_trip   = oc_rise & stage_oc_en;
	wire oov_trip  = out_ov_rise & out_ov_en;
	wire vin_trip  = (vin_uv_rise | vin_ov_rise) & vin_en;
	wire ot_trip   = (die_rise & die_ot_en) | (ext_rise & ext_ot_en);

	wire req_latch =
		(oc_trip & prot_cfg[STAGE_OC_LATCH_BIT]) | // R3
		(oov_trip & prot_cfg[OUT_MAX_OV_LATCH_BIT]) | // R4
		(vin_trip & prot_cfg[INPUT_LATCH_BIT]) | // R7
		(ov_trip & (ov_mode == MODE_LATCH)) | // R13
		(ov_trip & (ov_mode == MODE_RETRY) & ~ov_retry_ok) | // R14
		(uv_trip & (uv_mode == MODE_LATCH)) | // R16
		(uv_trip & (uv_mode == MODE_RETRY) & ~uv_retry_ok) |
		spike_rise; // R12

	wire req_hiccup =
		(oc_trip & ~prot_cfg[STAGE_OC_LATCH_BIT]) | // R3
		(oov_trip & ~prot_cfg[OUT_MAX_OV_LATCH_BIT]) | // R4
		(vin_trip & ~prot_cfg[INPUT_LATCH_BIT]) | // R7
		(ov_trip & (ov_mode == MODE_HICCUP)) | // R13
		(uv_trip & (uv_mode == MODE_HICCUP)); // R16

	// Lockout logging and status clear
	wire lockout_evt  = vin_uv_rise & vin_en; // R8
	wire nv_ok        = ~prot_cfg[LOCKOUT_NV_LOG_BIT] | flt.delivering; // R1
	wire post_ok      = ~prot_cfg[LOCKOUT_STATUS_BIT] | flt.delivering; // R9
	wire clear_evt    = prot_cfg[STATUS_CLEAR_EN_BIT] & (i_restart | power_off); // R10

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_resp         <= '0;
			o_active       <= '0;
			o_nv_log       <= 1'b0;
			o_status_post  <= 1'b0;
			o_status_clear <= 1'b0;
		end else begin
			// Latch-off holds until restart; a new trip in that cycle wins
			o_resp.latch_off <= req_latch | (o_resp.latch_off & ~i_restart);
			o_resp.hiccup    <= req_hiccup;
			o_resp.retry     <= ov_do_retry | uv_do_retry;
			o_resp.ot_trip   <= ot_trip; // R6
			o_active         <= '{vin: vin_en, stage_oc: stage_oc_en, out_max_ov: out_ov_en,
			                      die_ot: die_ot_en, ext_ot: ext_ot_en,
			                      window_armed: window_armed};
			o_nv_log         <= lockout_evt & nv_ok; // R1
			o_status_post    <= lockout_evt & post_ok; // R9
			o_status_clear   <= clear_evt; // R10
		end
	end

endmodule

`default_nettype wire

// ===== logic/pcr_pkg.sv
// Constants, field layout and carrier types for the protection configuration words.
// Assumes a 250 MHz core clock and an upstream command decoder that hands over whole words.
package pcr_pkg;

	// Command codes of the two words
	localparam logic [7:0]  CMD_PROT_CFG      = 8'h68;
	localparam logic [7:0]  CMD_VOUT_WIN      = 8'h69;
	localparam logic [15:0] PROT_CFG_RESET    = 16'h0000;
	localparam logic [15:0] VOUT_WIN_RESET    = 16'h0000;

	// Protection configuration word fields
	localparam int LOCKOUT_NV_LOG_BIT    = 15;
	localparam int STAGE_OC_LATCH_BIT    = 11;
	localparam int STAGE_OC_EN_BIT       = 10;
	localparam int OUT_MAX_OV_LATCH_BIT  = 9;
	localparam int OUT_MAX_OV_EN_BIT     = 8;
	localparam int DIE_OT_DIS_BIT        = 7;
	localparam int EXT_OT_DIS_BIT        = 6;
	localparam int INPUT_LATCH_BIT       = 5;
	localparam int INPUT_PROT_DIS_BIT    = 4;
	localparam int LOCKOUT_STATUS_BIT    = 3;
	localparam int STATUS_CLEAR_EN_BIT   = 2;
	localparam int ARM_CLK_SEL_BIT       = 1;
	localparam int MASTER_DIS_BIT        = 0;

	// Output window word fields
	localparam int VID_OV_MODE_LSB       = 14;
	localparam int VID_OV_RETRY_SEL_BIT  = 13;
	localparam int VID_OV_DELAY_LSB      = 8;
	localparam int VID_UV_MODE_LSB       = 6;
	localparam int VID_UV_DELAY_LSB      = 0;

	// Response encodings
	localparam logic [1:0] MODE_NONE     = 2'h0;
	localparam logic [1:0] MODE_LATCH    = 2'h1;
	localparam logic [1:0] MODE_HICCUP   = 2'h2;
	localparam logic [1:0] MODE_RETRY    = 2'h3;
	localparam logic [2:0] RETRY_FEW     = 3'h3;
	localparam logic [2:0] RETRY_MANY    = 3'h6;

	// Timing
	localparam int CLK_MHZ        = 250;
	localparam int OV_LSB_NS      = 200;
	localparam int OV_LSB_CYC     = OV_LSB_NS * CLK_MHZ / 1000;
	localparam int UV_LSB_US      = 20;
	localparam int UV_LSB_CYC     = UV_LSB_US * CLK_MHZ;
	localparam int ARM_SLOW_KHZ   = 20;
	localparam int ARM_FAST_KHZ   = 50;
	localparam int ARM_SLOW_CYC   = CLK_MHZ * 1000 / ARM_SLOW_KHZ;
	localparam int ARM_FAST_CYC   = CLK_MHZ * 1000 / ARM_FAST_KHZ;
	localparam logic [2:0] ARM_TICKS = 3'h4;

	// Comparator and pin levels from outside the clock domain
	typedef struct packed {
		logic vin_uv;
		logic vin_ov;
		logic stage_oc;
		logic out_max_ov;
		logic die_ot;
		logic ext_ot;
		logic vid_ov;
		logic vid_uv;
		logic en_pin;
		logic ton_normal;
		logic delivering;
		logic high_spike_shutdown;
	} pcr_fault_in_t;

	typedef struct packed {
		logic latch_off;
		logic hiccup;
		logic retry;
		logic ot_trip;
	} pcr_resp_t;

	typedef struct packed {
		logic vin;
		logic stage_oc;
		logic out_max_ov;
		logic die_ot;
		logic ext_ot;
		logic window_armed;
	} pcr_active_t;

	typedef enum logic [2:0] {
		ARM_IDLE  = 3'h1,
		ARM_WAIT  = 3'h2,
		ARM_READY = 3'h4
	} pcr_arm_state_t;

	// Number of allowed retries in retry mode
	function automatic logic [2:0] pcr_retry_limit(input logic few_sel);
		pcr_retry_limit = few_sel ? RETRY_FEW : RETRY_MANY;
	endfunction

endpackage

// ===== sim/pcr_checker_sva.sv
// Port checker for the protection configuration words.
// Assumes one clock and async low reset; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module pcr_checker_sva #(
	parameter int UV_LSB_CYC   = 20,
	parameter int ARM_SLOW_CYC = 25,
	parameter int ARM_FAST_CYC = 10
) (
	input wire logic                   i_clk,
	input wire logic                   i_resetn,
	input wire logic [7:0]             i_cmd,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [15:0]            i_wdata,
	input wire pcr_pkg::pcr_fault_in_t i_faults,
	input wire logic                   i_restart,
	input wire logic                   i_op_off,
	input wire logic [15:0]            o_rdata,
	input wire logic                   o_ack,
	input wire logic                   o_nack,
	input wire pcr_pkg::pcr_resp_t     o_resp,
	input wire pcr_pkg::pcr_active_t   o_active,
	input wire logic                   o_nv_log,
	input wire logic                   o_status_post,
	input wire logic                   o_status_clear
);
	import pcr_pkg::*;
	logic [15:0] cfg;
	wire         known = i_cmd == CMD_PROT_CFG || i_cmd == CMD_VOUT_WIN;
	wire         req   = i_wr || i_rd;
	wire         on    = !cfg[MASTER_DIS_BIT];
	// Own copy of the word, so expectations never lean on design state
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			cfg <= PROT_CFG_RESET;
		else if (i_wr && i_cmd == CMD_PROT_CFG)
			cfg <= i_wdata;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Enable levels lag the word by a cycle, so wait out a quiet stretch
	sequence s_quiet;
		!i_wr [*3];
	endsequence
	chk_ack_known: assert property (req && known |=> o_ack && !o_nack)
		else $error("known access not acknowledged");
	chk_nack_unknown: assert property (req && !known |=> o_nack && !o_ack)
		else $error("unknown access not refused");
	chk_quiet_bus: assert property (!req |=> !o_ack && !o_nack)
		else $error("answer without request");
	chk_read_back: assert property (i_rd && !i_wr && i_cmd == CMD_PROT_CFG |=> o_rdata == cfg)
		else $error("read data differs from written word");
	chk_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved without read");
	chk_latch_hold: assert property (o_resp.latch_off && !i_restart |=> o_resp.latch_off)
		else $error("latch-off dropped without restart");
	chk_oc_gate: assert property (s_quiet |=> o_active.stage_oc == (on && cfg[STAGE_OC_EN_BIT]))
		else $error("stage overcurrent enable wrong");
	chk_ov_gate: assert property (s_quiet |=> o_active.out_max_ov == (on && cfg[OUT_MAX_OV_EN_BIT]))
		else $error("output overvolt enable wrong");
	chk_die_gate: assert property (s_quiet |=> o_active.die_ot == (on && !cfg[DIE_OT_DIS_BIT]))
		else $error("die overtemp enable wrong");
	chk_ext_gate: assert property (s_quiet |=> o_active.ext_ot == (on && !cfg[EXT_OT_DIS_BIT]))
		else $error("external overtemp enable wrong");
	chk_vin_gate: assert property (s_quiet |=> o_active.vin == (on && !cfg[INPUT_PROT_DIS_BIT]))
		else $error("input protection enable wrong");
	chk_clear_set: assert property ((i_restart || i_op_off) && cfg[STATUS_CLEAR_EN_BIT] |=> o_status_clear)
		else $error("status clear missing");
	chk_clear_gate: assert property (!cfg[STATUS_CLEAR_EN_BIT] |=> !o_status_clear)
		else $error("status clear while not selected");
endmodule
bind pcr_protection_config_regs pcr_checker_sva #(
	.UV_LSB_CYC(UV_LSB_CYC), .ARM_SLOW_CYC(ARM_SLOW_CYC), .ARM_FAST_CYC(ARM_FAST_CYC)
) pcr_checker_sva_inst (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(i_cmd), .i_wr(i_wr), .i_rd(i_rd),
	.i_wdata(i_wdata), .i_faults(i_faults), .i_restart(i_restart), .i_op_off(i_op_off),
	.o_rdata(o_rdata), .o_ack(o_ack), .o_nack(o_nack), .o_resp(o_resp),
	.o_active(o_active), .o_nv_log(o_nv_log), .o_status_post(o_status_post),
	.o_status_clear(o_status_clear)
);
`default_nettype wire

// ===== sim/pcr_host_model.sv
// Host controller model issuing whole-word command accesses.
// Assumes the answer lands one edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_ack,
	output logic [7:0]       o_cmd,
	output logic             o_wr,
	output logic             o_rd,
	output logic [15:0]      o_wdata
);
	initial begin
		o_cmd = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end
	task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		@(posedge i_clk);
		o_cmd <= c;
		o_wr <= w;
		o_rd <= !w;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		// Released data is inverted so a stale value cannot pass
		o_wdata <= ~d;
		#1;
		q = i_rdata;
		ok = i_ack;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_protection_config_regs.sv
// Self-checking bench for the protection configuration words.
// Assumes short arming counts; host accesses go through the host model.
`timescale 1ns/1ps
`default_nettype none
module tb_protection_config_regs;
	import pcr_pkg::*;
	logic          i_clk = 1'b0;
	logic          i_resetn = 1'b0;
	logic          i_restart = 1'b0;
	logic          op_off = 1'b0;
	logic          clr;
	int            cnt;
	pcr_fault_in_t i_faults = '0;
	logic [7:0]    cmd;
	logic          wr;
	logic          rd;
	logic          ack;
	logic          nack;
	logic          ok;
	logic          nv;
	logic          post;
	logic [15:0]   wdata;
	logic [15:0]   rdata;
	logic [15:0]   q;
	logic [15:0]   last;
	pcr_resp_t     resp;
	pcr_active_t   act;
	pcr_fault_in_t f;
	logic [31:0]   seed = 32'h0001_3A94;
	int            err_count = 0;
	int            total_checks = 0;
	int            n;
	always #2 i_clk = ~i_clk;
	pcr_protection_config_regs #(.UV_LSB_CYC(20), .ARM_SLOW_CYC(25), .ARM_FAST_CYC(10))
	pcr_protection_config_regs_inst (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(cmd), .i_wr(wr), .i_rd(rd),
		.i_wdata(wdata), .i_faults(i_faults), .i_restart(i_restart), .i_op_off(op_off),
		.o_rdata(rdata), .o_ack(ack), .o_nack(nack), .o_resp(resp), .o_active(act),
		.o_nv_log(nv), .o_status_post(post), .o_status_clear(clr)
	);
	pcr_host_model pcr_host_model_inst (
		.i_clk(i_clk), .i_rdata(rdata), .i_ack(ack), .o_cmd(cmd), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Flags in order: latch_off, hiccup, ot_trip, nv_log, status_post
	function automatic logic [4:0] exp_resp(input logic [15:0] c, input pcr_fault_in_t f);
		logic en, oc, om, vi, lu;
		en = !c[MASTER_DIS_BIT];
		oc = en && f.stage_oc && c[STAGE_OC_EN_BIT];
		om = en && f.out_max_ov && c[OUT_MAX_OV_EN_BIT];
		vi = en && !c[INPUT_PROT_DIS_BIT] && (f.vin_uv || f.vin_ov);
		lu = en && !c[INPUT_PROT_DIS_BIT] && f.vin_uv;
		return {f.high_spike_shutdown || oc && c[11] || om && c[9] || vi && c[5],
			oc && !c[11] || om && !c[9] || vi && !c[5],
			en && (f.die_ot && !c[7] || f.ext_ot && !c[6]),
			lu && (!c[15] || f.delivering), lu && (!c[3] || f.delivering)};
	endfunction
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flags(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t flags got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic restart();
		@(posedge i_clk);
		i_restart <= 1'b1;
		@(posedge i_clk);
		i_restart <= 1'b0;
	endtask
	task automatic try(input logic [15:0] c, input pcr_fault_in_t f);
		logic [4:0] seen;
		seen = '0;
		pcr_host_model_inst.access(1'b1, CMD_PROT_CFG, c, q, ok);
		restart();
		i_faults <= f;
		repeat (12) begin
			@(posedge i_clk);
			seen |= {resp.latch_off, resp.hiccup, resp.ot_trip, nv, post};
		end
		i_faults <= '0;
		repeat (6) @(posedge i_clk);
		chk_flags({3'h0, seen}, {3'h0, exp_resp(c, f)});
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		pcr_host_model_inst.access(1'b0, CMD_PROT_CFG, 16'h0000, q, ok);
		chk_word(q, PROT_CFG_RESET);
		pcr_host_model_inst.access(1'b0, CMD_VOUT_WIN, 16'h0000, q, ok);
		chk_word(q, VOUT_WIN_RESET);
		for (int i = 0; i < 8; i++) begin
			last = 16'(rnd());
			pcr_host_model_inst.access(1'b1, i[0] ? CMD_VOUT_WIN : CMD_PROT_CFG, last, q, ok);
			pcr_host_model_inst.access(1'b0, i[0] ? CMD_VOUT_WIN : CMD_PROT_CFG, 16'h0000, q, ok);
			chk_word(q, last);
		end
		pcr_host_model_inst.access(1'b1, 8'h6A, 16'hFFFF, q, ok);
		pcr_host_model_inst.access(1'b0, 8'h6A, 16'h0000, q, ok);
		chk_word(q, 16'h0000);
		chk_flags({7'h00, ok}, 8'h00);
		pcr_host_model_inst.access(1'b0, CMD_VOUT_WIN, 16'h0000, q, ok);
		chk_word(q, last);
		try(16'h0C00, 12'h280);
		try(16'h7480, 12'h280);
		try(16'h0C01, 12'h280);
		try(16'h8020, 12'h800);
		try(16'h8008, 12'h802);
		try(16'h0018, 12'h800);
		try(16'h0001, 12'h001);
		for (int i = 0; i < 10; i++) begin
			n = rnd() % 7;
			f = (n == 6) ? 12'h001 : 12'h001 << (11 - n);
			f.delivering = 1'(rnd());
			try(16'(rnd()), f);
		end
		pcr_host_model_inst.access(1'b1, CMD_PROT_CFG, 16'h0000, q, ok);
		pcr_host_model_inst.access(1'b1, CMD_VOUT_WIN, {MODE_LATCH, 1'b0, 5'h01, 8'h00}, q, ok);
		restart();
		i_faults.ton_normal <= 1'b1;
		for (n = 0; act.window_armed !== 1'b1 && n < 200; n++) @(posedge i_clk);
		chk_flags({7'h00, n >= 40 && n <= 48}, 8'h01);
		i_faults.vid_ov <= 1'b1;
		repeat (30) @(posedge i_clk);
		i_faults.vid_ov <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_faults.vid_ov <= 1'b1;
		for (n = 0; resp.latch_off !== 1'b1 && n < 300; n++) @(posedge i_clk);
		chk_flags({7'h00, n >= OV_LSB_CYC && n <= OV_LSB_CYC + 8}, 8'h01);
		// Retry budget is only refilled at power-off, so restart keeps the count
		i_faults.vid_ov <= 1'b0;
		pcr_host_model_inst.access(1'b1, CMD_VOUT_WIN, {MODE_RETRY, 1'b1, 5'h00, 8'h00}, q, ok);
		restart();
		cnt = 0;
		repeat (4) begin
			i_faults.vid_ov <= 1'b1;
			repeat (8) begin
				@(posedge i_clk);
				cnt += resp.retry;
			end
			i_faults.vid_ov <= 1'b0;
			repeat (6) @(posedge i_clk);
		end
		chk_flags({3'h0, 4'(cnt), resp.latch_off}, {3'h0, 4'(RETRY_FEW), 1'b1});
		for (int k = 0; k < 2; k++) begin
			pcr_host_model_inst.access(1'b1, CMD_PROT_CFG, {13'h0000, k[0], 2'h0}, q, ok);
			cnt = 0;
			restart();
			repeat (2) begin
				@(posedge i_clk);
				cnt += clr;
			end
			op_off <= 1'b1;
			@(posedge i_clk);
			op_off <= 1'b0;
			repeat (2) begin
				@(posedge i_clk);
				cnt += clr;
			end
			chk_flags({6'h00, 2'(cnt)}, k[0] ? 8'h02 : 8'h00);
		end
		finish_test();
	end
endmodule
`default_nettype wire
